// [src/gpp_pkg.sv]
// Purpose: Shared constants and types for the general-purpose I/O port block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package gpp_pkg;
  localparam int unsigned GPP_PORT_W = 8;
  localparam int unsigned GPP_ADDR_W = 8;
  localparam logic [7:0] GPP_OFF_OUT = 8'h00;
  localparam logic [7:0] GPP_OFF_DIR = 8'h04;
  localparam logic [7:0] GPP_OFF_PIN = 8'h08;
  localparam logic [7:0] GPP_OFF_CTRL = 8'h0C;
  localparam logic [7:0] GPP_OFF_SET = 8'h10;
  localparam logic [7:0] GPP_OFF_CLR = 8'h14;
  localparam int unsigned GPP_CTRL_PUD_BIT = 0;
  localparam int unsigned GPP_CTRL_SLEEP_BIT = 1;
  localparam int unsigned GPP_SETCLR_DIR_LSB = 8;
  localparam logic [7:0] GPP_RST_BYTE = 8'h00;
  localparam logic [1:0] GPP_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] out_val;
    logic [7:0] pullup_en;
  } gpp_pad_ctl_t;

  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] alt_sleep_ovr;
  } gpp_keep_t;
endpackage : gpp_pkg

// [src/gpp_port.sv]
// Purpose: Eight-pin general-purpose I/O port with AXI4-Lite registers
// Assumes: aclk 25 MHz, synchronous active-low aresetn; pad cells outside
// Notes: Pad enables are gated combinationally by reset so pins float with no clock
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RL1] Each port has output-data, direction and pin-input register locations.
// [RL2] Pin-input is read-only storage; output-data and direction are read/write.
// [RL3] Writing one to a pin-input bit inverts the matching output-data bit.
// [RL4] Global pull-up disable turns off every pull-up.
// [RL5] Direction one makes a pin an output, zero an input.
// [RL6] Pull-up on only for direction zero, data one, disable clear.
// [RL7] Input with data zero floats; clearing data or outputting drops pull-up.
// [RL8] Output pins drive the output-data bit level.
// [RL9] During reset all pins are tristated, even without a clock.
// [RL10] Software passes an intermediate state between tri-state and output high.
// [RL11] Software passes an intermediate state between pull-up input and output low.
// [RL12] Pin level is readable through pin-input whatever the direction.
// [RL13] Each input passes a high-transparent latch then a rising-edge register.
// [RL14] Written output value reaches pin-input one clock period after the write.
// [RL15] Software waits one idle step before reading back a written pin.
// [RL16] Single-bit set and clear leave other pins unchanged.
// [RL17] Alternate functions on some pins leave the others unaffected.
// [RL18] Deep sleep clamps inputs low, except interrupt or override pins.
// [RL19] Each port is eight bits; bit n of every register is pin n; here CTRL bits are not pins, SET/CLR bits 8-15 are DIR bits.
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned PORT_W = gpp_pkg::GPP_PORT_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gpp_pkg::GPP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpp_pkg::GPP_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PORT_W-1:0] pin_i,
  output logic [PORT_W-1:0] pin_o,
  output logic [PORT_W-1:0] pin_oe,
  output logic [PORT_W-1:0] pin_pullup_en,
  input wire logic sleep_deep,
  input wire gpp_pkg::gpp_keep_t input_keep
);
  import gpp_pkg::*;

  logic [PORT_W-1:0] output_data_reg_r;
  logic [PORT_W-1:0] direction_reg_r;
  logic [PORT_W-1:0] pin_input_reg_r;
  logic [PORT_W-1:0] sync_latch;
  logic [PORT_W-1:0] pin_clamped;
  logic global_pullup_disable_r;
  logic [gpp_pkg::GPP_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r;
  logic w_have_r;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  gpp_pad_ctl_t pad;

  // Read-as-zero above the port width on every register
  function automatic logic [31:0] gpp_widen(input logic [PORT_W-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PORT_W-1:0] = v;
    return w;
  endfunction

  function automatic logic gpp_known(input logic [gpp_pkg::GPP_ADDR_W-1:0] a);
    return (a == GPP_OFF_OUT) || (a == GPP_OFF_DIR) || (a == GPP_OFF_PIN) ||
           (a == GPP_OFF_CTRL) || (a == GPP_OFF_SET) || (a == GPP_OFF_CLR);
  endfunction

  // Write channels are captured independently so either may arrive first
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_hit = gpp_known(aw_addr_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_have_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_have_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GPP_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? GPP_RESP_OKAY : GPP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Output-data: plain write, toggle via pin-input writes, set/clear words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      output_data_reg_r <= GPP_RST_BYTE[PORT_W-1:0];
    else if (wr_fire && w_strb_r[0])
    begin
      unique case (aw_addr_r)
        GPP_OFF_OUT: output_data_reg_r <= w_data_r[PORT_W-1:0]; // see [RL2]
        GPP_OFF_PIN: output_data_reg_r <= output_data_reg_r ^ w_data_r[PORT_W-1:0]; // see [RL3]
        GPP_OFF_SET: output_data_reg_r <= output_data_reg_r | w_data_r[PORT_W-1:0]; // see [RL16]
        GPP_OFF_CLR: output_data_reg_r <= output_data_reg_r & ~w_data_r[PORT_W-1:0]; // see [RL16]
        default: output_data_reg_r <= output_data_reg_r;
      endcase
    end
  end

  // Direction: byte lane 1 of the set/clear words addresses direction bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      direction_reg_r <= GPP_RST_BYTE[PORT_W-1:0];
    else if (wr_fire && (aw_addr_r == GPP_OFF_DIR) && w_strb_r[0])
      direction_reg_r <= w_data_r[PORT_W-1:0]; // see [RL2]
    else if (wr_fire && (aw_addr_r == GPP_OFF_SET) && w_strb_r[1])
      direction_reg_r <= direction_reg_r |
        w_data_r[GPP_SETCLR_DIR_LSB +: PORT_W]; // see [RL16]
    else if (wr_fire && (aw_addr_r == GPP_OFF_CLR) && w_strb_r[1])
      direction_reg_r <= direction_reg_r &
        ~w_data_r[GPP_SETCLR_DIR_LSB +: PORT_W]; // see [RL16]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      global_pullup_disable_r <= 1'b0;
    else if (wr_fire && (aw_addr_r == GPP_OFF_CTRL) && w_strb_r[0])
      global_pullup_disable_r <= w_data_r[GPP_CTRL_PUD_BIT];
  end

  // Pad control; reset gates both enables combinationally so no clock edge is needed
  always_comb
  begin
    pad.out_en = aresetn ? direction_reg_r : '0; // see [RL5] [RL9]
    pad.out_val = output_data_reg_r; // see [RL8]
    pad.pullup_en = (aresetn && !global_pullup_disable_r) ?
      (~direction_reg_r & output_data_reg_r) : '0; // see [RL4] [RL6] [RL7]
  end

  assign pin_oe = pad.out_en;
  assign pin_o = pad.out_val;
  assign pin_pullup_en = pad.pullup_en;

  // Deep-sleep clamp ahead of the synchronizer, bypassed per pin
  assign pin_clamped = sleep_deep ?
    (pin_i & (input_keep.irq_en | input_keep.alt_sleep_ovr)) : pin_i; // see [RL18] [RL17]

  // High-transparent latch is the first synchronizer stage; only the
  // capturing register below reads it. Half-cycle settle is the trade-off.
  always_latch
  begin
    if (aclk)
      sync_latch <= pin_clamped; // see [RL13]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_input_reg_r <= GPP_RST_BYTE[PORT_W-1:0];
    else
      pin_input_reg_r <= sync_latch; // see [RL13] [RL12] [RL14]
  end

  // Read channel: one cycle to answer, held until rready
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit = gpp_known(s_axi_araddr);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      GPP_OFF_OUT: rd_word = gpp_widen(output_data_reg_r); // see [RL1]
      GPP_OFF_DIR: rd_word = gpp_widen(direction_reg_r); // see [RL1]
      GPP_OFF_PIN: rd_word = gpp_widen(pin_input_reg_r); // see [RL1] [RL12]
      GPP_OFF_CTRL:
      begin
        rd_word[GPP_CTRL_PUD_BIT] = global_pullup_disable_r;
        rd_word[GPP_CTRL_SLEEP_BIT] = sleep_deep;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= GPP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? GPP_RESP_OKAY : GPP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // gpp_port
`default_nettype wire

// [tb/gpp_pad_model.sv]
// Purpose: Pads and outside drivers for gpp_port
// Assumes: Outside drivers beat pull-ups
// Notes: Undriven pins without pull-up toggle each cycle
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_model (
  input wire logic aclk,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  logic [7:0] flt_r = 8'h00;
  // A floating pin never shows a stale level
  // Plain always: the power-up value above would be a second driver to always_ff
  always @(posedge aclk) flt_r <= ~flt_r;
  always_comb pin_i = pin_oe & pin_o | ~pin_oe & (ext_en & ext_val
    | ~ext_en & (pin_pullup_en | flt_r));
endmodule // gpp_pad_model
`default_nettype wire

// [tb/gpp_port_assertions.sv]
// Purpose: Port-level checks for gpp_port
// Assumes: One clock domain
// Notes: Bound to every gpp_port
`timescale 1ns/1ns
`default_nettype none
module gpp_port_assertions #(
  parameter int unsigned PORT_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PORT_W-1:0] pin_o,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic [PORT_W-1:0] pin_pullup_en
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("no write answer");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("no read answer");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_pullup_cfg: assert property ((pin_pullup_en & (pin_oe | ~pin_o)) == '0)
    else $error("pull-up on in wrong state");
  chk_pin_cause: assert property (!$stable(pin_o) || !$stable(pin_oe) |-> $rose(s_axi_bvalid))
    else $error("pad control moved without write");
endmodule // gpp_port_assertions
bind gpp_port gpp_port_assertions #(.PORT_W(PORT_W)) gpp_port_assertions_i (.*);
`default_nettype wire

// [tb/gpp_port_pin_logic_tb_top.sv]
// Purpose: Self-checking bench for gpp_port
// Assumes: Pad model closes the pin loop
// Notes: Bus waits end only by the cycle ceiling
`timescale 1ns/1ns
`default_nettype none
module gpp_port_pin_logic_tb_top;
  import gpp_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, sleep_deep = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] pin_i, pin_o, pin_oe, pin_pullup_en;
  gpp_keep_t input_keep = '0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  gpp_port gpp_port_i (.*);
  gpp_pad_model gpp_pad_model_i (.*);
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One access at a time; every request is held until its ready edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [15:0] d,
    input logic [1:0] e = GPP_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= !rd;
    s_axi_wvalid <= !rd;
    s_axi_bready <= !rd;
    s_axi_arvalid <= rd;
    s_axi_rready <= rd;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!(rd ? s_axi_rvalid : s_axi_bvalid));
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    chk(rd ? s_axi_rresp : s_axi_bresp, e);
    if (rd)
      chk(s_axi_rdata, {16'h0000, d});
  endtask
  task automatic t_regs();
    bus(1'h0, GPP_OFF_OUT, 16'h00A5);
    bus(1'h1, GPP_OFF_OUT, 16'h00A5);
    bus(1'h0, GPP_OFF_PIN, 16'h000F);
    bus(1'h1, GPP_OFF_OUT, 16'h00AA);
    bus(1'h0, GPP_OFF_SET, 16'h4001);
    bus(1'h0, GPP_OFF_CLR, 16'h0880);
    bus(1'h1, GPP_OFF_OUT, 16'h002B);
    bus(1'h1, GPP_OFF_DIR, 16'h0040);
    bus(1'h1, 8'h20, 16'h0000, GPP_RESP_SLVERR);
    $display("t_regs done");
  endtask
  task automatic t_pads();
    bus(1'h0, GPP_OFF_DIR, 16'h0000);
    bus(1'h0, GPP_OFF_OUT, 16'h00FF);
    chk(pin_pullup_en, 8'hFF);
    bus(1'h0, GPP_OFF_CTRL, 16'h0001);
    chk(pin_pullup_en, 8'h00);
    bus(1'h0, GPP_OFF_CTRL, 16'h0000);
    bus(1'h0, GPP_OFF_CLR, 16'h000F);
    chk(pin_pullup_en, 8'hF0);
    // Pins heading for output high pass through pull-up input first
    bus(1'h0, GPP_OFF_OUT, 16'h003C);
    bus(1'h0, GPP_OFF_DIR, 16'h00FF);
    chk(pin_oe, 8'hFF);
    chk(pin_o, 8'h3C);
    bus(1'h1, GPP_OFF_PIN, 16'h003C);
    $display("t_pads done");
  endtask
  task automatic t_ext();
    bus(1'h0, GPP_OFF_DIR, 16'h0000);
    ext_en <= 8'hFF;
    ext_val <= 8'h5A;
    bus(1'h1, GPP_OFF_PIN, 16'h005A);
    sleep_deep <= 1'h1;
    input_keep <= '{irq_en: 8'h03, alt_sleep_ovr: 8'h30};
    ext_val <= 8'hFF;
    bus(1'h1, GPP_OFF_PIN, 16'h0033);
    bus(1'h1, GPP_OFF_CTRL, 16'h0002);
    sleep_deep <= 1'h0;
    ext_en <= 8'h00;
    $display("t_ext done");
  endtask
  task automatic t_reset();
    bus(1'h0, GPP_OFF_DIR, 16'h000F);
    aresetn <= 1'h0;
    #1;
    chk(pin_oe, 8'h00);
    chk(pin_pullup_en, 8'h00);
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    bus(1'h1, GPP_OFF_OUT, 16'h0000);
    $display("t_reset done");
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_pads();
    t_ext();
    t_reset();
    tally_and_finish();
  end
endmodule // gpp_port_pin_logic_tb_top
`default_nettype wire
